// [src/ccd_clock_unit.sv]
// clock generation and distribution unit with APB register access
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module ccd_clock_unit
  import ccd_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES,
  parameter int DIV_W = 16
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_main_osc,
  input wire logic fast_crystal_osc,
  input wire logic fabric_clk,
  input wire logic pll_core_clk,
  input wire logic low_speed_osc,
  input wire logic watch_crystal_osc,
  input wire logic hibernate,
  input wire logic debug_halt,
  output logic [2:0] imo_freq_sel,
  output logic [7:0] imo_trim,
  output logic pll_enable,
  output logic [5:0] pll_in_div,
  output logic [5:0] pll_fb_div,
  output logic pll_locked,
  output logic dbl_clk,
  output logic usb_clk,
  output logic sys_clk,
  output logic bus_clk,
  output logic cpu_clk,
  output logic [NUM_DIG_DIV-1:0] dig_clk,
  output logic [NUM_ANA_DIV-1:0] ana_clk,
  output logic slow_tick_clock,
  output logic third_rate_slow_clock,
  output logic fast_low_power_clock,
  output logic wake_event,
  output logic wake_irq,
  output logic ftw_irq
);
  // control registers
  logic [2:0] imo_freq_reg;
  logic [7:0] trim_reg [NUM_IMO_RANGES];
  ccd_ref_e dbl_ref_reg;
  ccd_ref_e pll_ref_reg;
  logic pll_en_reg;
  logic usb_from_dbl_reg;
  logic [2:0] sys_sel_reg;
  logic [5:0] pll_p_reg;
  logic [5:0] pll_q_reg;
  logic [12:0] wake_period_reg;
  logic wake_en_reg;
  logic wake_irq_en_reg;
  logic [4:0] ftw_tc_reg;
  logic ftw_en_reg;
  logic ftw_irq_en_reg;
  logic [15:0] bus_ratio_reg;
  ccd_div_cfg_s dig_cfg_reg [NUM_DIG_DIV];
  ccd_div_cfg_s ana_cfg_reg [NUM_ANA_DIV];
  // internal state
  logic [16:0] lock_cnt_reg;
  logic locked_reg;
  logic dbl_prev_reg;
  logic lso_prev_reg;
  logic [5:0] lso_1k_cnt_reg;
  logic [1:0] lso_33k_cnt_reg;
  logic [12:0] wake_cnt_reg;
  logic [12:0] wake_phase_reg;
  logic [4:0] ftw_cnt_reg;
  logic bus_div_q;
  // decode
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_value;
  logic rd_hit;
  logic pll_ref_level;
  logic dbl_ref_level;
  logic lso_rise;
  logic lso_edge;
  logic tick_1k;
  logic pll_src;
  logic [7:0] src_levels;
  ccd_div_cfg_s bus_cfg;

  assign wr_go = psel & penable & pready & pwrite;
  assign rd_go = psel & penable & ~pready;

  always_comb
  begin
    unique case (dbl_ref_reg)
      CCD_REF_IMO: dbl_ref_level = internal_main_osc;
      CCD_REF_ECO: dbl_ref_level = fast_crystal_osc;
      CCD_REF_FABRIC: dbl_ref_level = fabric_clk;
      default: dbl_ref_level = internal_main_osc;
    endcase
  end

  always_comb
  begin
    unique case (pll_ref_reg)
      CCD_REF_IMO: pll_ref_level = internal_main_osc;
      CCD_REF_ECO: pll_ref_level = fast_crystal_osc;
      CCD_REF_FABRIC: pll_ref_level = fabric_clk;
      default: pll_ref_level = internal_main_osc;
    endcase
  end

  assign pll_src = locked_reg ? pll_core_clk : pll_ref_level;
  assign src_levels = {watch_crystal_osc, fast_low_power_clock, slow_tick_clock, dbl_clk,
                       pll_src, fabric_clk, fast_crystal_osc, internal_main_osc};

  // APB write side
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      imo_freq_reg <= IMO_FREQ_RST;
      dbl_ref_reg <= CCD_REF_IMO;
      pll_ref_reg <= CCD_REF_IMO;
      pll_en_reg <= 1'b0;
      usb_from_dbl_reg <= 1'b0;
      sys_sel_reg <= SRC_IMO;
      pll_p_reg <= PLL_P_RST;
      pll_q_reg <= PLL_Q_RST;
      wake_period_reg <= WAKE_PERIOD_RST;
      wake_en_reg <= 1'b0;
      wake_irq_en_reg <= 1'b0;
      ftw_tc_reg <= FTW_TC_RST;
      ftw_en_reg <= 1'b0;
      ftw_irq_en_reg <= 1'b0;
      bus_ratio_reg <= DIV_RST;
      for (int i = 0; i < NUM_IMO_RANGES; i++)
        trim_reg[i] <= IMO_TRIM_RST;
      for (int i = 0; i < NUM_DIG_DIV; i++)
        dig_cfg_reg[i] <= DIV_CFG_RST;
      for (int i = 0; i < NUM_ANA_DIV; i++)
        ana_cfg_reg[i] <= DIV_CFG_RST;
    end
    else if (wr_go)
    begin
      unique case (paddr)
        OSC_CTRL_OFS:
        begin
          if (pwdata[2:0] <= IMO_FREQ_MAX)
            imo_freq_reg <= pwdata[2:0];
          if (pwdata[5:4] != 2'b11)
            dbl_ref_reg <= ccd_ref_e'(pwdata[5:4]);
          pll_en_reg <= pwdata[8];
          if (pwdata[11:10] != 2'b11)
            pll_ref_reg <= ccd_ref_e'(pwdata[11:10]);
          usb_from_dbl_reg <= pwdata[12];
          sys_sel_reg <= pwdata[18:16];
        end
        PLL_DIV_OFS:
        begin
          pll_p_reg <= pwdata[5:0];
          pll_q_reg <= pwdata[13:8];
        end
        WAKE_CTRL_OFS:
        begin
          wake_period_reg <= pwdata[12:0];
          wake_en_reg <= pwdata[16];
          wake_irq_en_reg <= pwdata[17];
        end
        FTW_CTRL_OFS:
        begin
          ftw_tc_reg <= pwdata[4:0];
          ftw_en_reg <= pwdata[8];
          ftw_irq_en_reg <= pwdata[9];
        end
        BUS_DIV_OFS: bus_ratio_reg <= pwdata[15:0];
        default:
        begin
          if (paddr >= DIG_DIV_OFS && paddr < DIG_DIV_OFS + 8'(4 * NUM_DIG_DIV))
            dig_cfg_reg[3'((paddr - DIG_DIV_OFS) >> 2)] <=
              '{en: pwdata[24], sel: pwdata[18:16], ratio: pwdata[15:0], skew: 2'h0};
          else if (paddr >= ANA_DIV_OFS && paddr < ANA_DIV_OFS + 8'(4 * NUM_ANA_DIV))
            ana_cfg_reg[2'((paddr - ANA_DIV_OFS) >> 2)] <=
              '{en: pwdata[24], sel: pwdata[18:16], ratio: pwdata[15:0], skew: pwdata[27:26]};
          else if (paddr >= IMO_TRIM_OFS && paddr < IMO_TRIM_OFS + 8'(4 * NUM_IMO_RANGES))
            trim_reg[3'((paddr - IMO_TRIM_OFS) >> 2)] <= pwdata[7:0];
        end
      endcase
    end
  end

  // read mux
  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      OSC_CTRL_OFS: rd_value = {13'h0000, sys_sel_reg, 3'h0, usb_from_dbl_reg, pll_ref_reg, 1'b0,
                                pll_en_reg, 2'h0, dbl_ref_reg, 1'b0, imo_freq_reg};
      PLL_DIV_OFS: rd_value = {18'h00000, pll_q_reg, 2'h0, pll_p_reg};
      STATUS_OFS: rd_value = {3'h0, wake_cnt_reg, 3'h0, ftw_cnt_reg, 7'h00, locked_reg};
      WAKE_CTRL_OFS: rd_value = {14'h0000, wake_irq_en_reg, wake_en_reg, 3'h0, wake_period_reg};
      FTW_CTRL_OFS: rd_value = {22'h000000, ftw_irq_en_reg, ftw_en_reg, 3'h0, ftw_tc_reg};
      BUS_DIV_OFS: rd_value = {16'h0000, bus_ratio_reg};
      default:
      begin
        if (paddr >= DIG_DIV_OFS && paddr < DIG_DIV_OFS + 8'(4 * NUM_DIG_DIV))
          rd_value = {7'h00, dig_cfg_reg[3'((paddr - DIG_DIV_OFS) >> 2)].en, 5'h00,
                      dig_cfg_reg[3'((paddr - DIG_DIV_OFS) >> 2)].sel,
                      dig_cfg_reg[3'((paddr - DIG_DIV_OFS) >> 2)].ratio};
        else if (paddr >= ANA_DIV_OFS && paddr < ANA_DIV_OFS + 8'(4 * NUM_ANA_DIV))
          rd_value = {4'h0, ana_cfg_reg[2'((paddr - ANA_DIV_OFS) >> 2)].skew, 1'b0,
                      ana_cfg_reg[2'((paddr - ANA_DIV_OFS) >> 2)].en, 5'h00,
                      ana_cfg_reg[2'((paddr - ANA_DIV_OFS) >> 2)].sel,
                      ana_cfg_reg[2'((paddr - ANA_DIV_OFS) >> 2)].ratio};
        else if (paddr >= IMO_TRIM_OFS && paddr < IMO_TRIM_OFS + 8'(4 * NUM_IMO_RANGES))
          rd_value = {24'h000000, trim_reg[3'((paddr - IMO_TRIM_OFS) >> 2)]};
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_go;
      pslverr <= rd_go & ~rd_hit;
      if (rd_go)
        prdata <= pwrite ? 32'h0000_0000 : rd_value;
    end
  end

  // frequency code and trim to oscillator
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      imo_freq_sel <= IMO_FREQ_RST;
      imo_trim <= IMO_TRIM_RST;
      pll_enable <= 1'b0;
      pll_in_div <= PLL_P_RST;
      pll_fb_div <= PLL_Q_RST;
    end
    else
    begin
      imo_freq_sel <= imo_freq_reg;
      imo_trim <= trim_reg[imo_freq_reg];
      pll_enable <= pll_en_reg;
      pll_in_div <= pll_p_reg;
      pll_fb_div <= pll_q_reg;
    end
  end

  // lock timer, restarts on PLL disable or on any write to OSC_CTRL_OFS or PLL_DIV_OFS
  always_ff @(posedge clk_sys)
  begin
    if (reset || !pll_en_reg || (wr_go && (paddr == PLL_DIV_OFS || paddr == OSC_CTRL_OFS)))
    begin
      lock_cnt_reg <= 17'h00000;
      locked_reg <= 1'b0;
    end
    else if (lock_cnt_reg >= 17'(LOCK_CYCLES - 1))
      locked_reg <= 1'b1;
    else
      lock_cnt_reg <= lock_cnt_reg + 17'h00001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pll_locked <= 1'b0;
    else
      pll_locked <= locked_reg;
  end

  // pulse on both input edges doubles rate
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dbl_prev_reg <= 1'b0;
      dbl_clk <= 1'b0;
    end
    else
    begin
      dbl_prev_reg <= dbl_ref_level;
      dbl_clk <= dbl_ref_level ^ dbl_prev_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      usb_clk <= 1'b0;
      sys_clk <= 1'b0;
    end
    else
    begin
      usb_clk <= usb_from_dbl_reg ? dbl_clk : fabric_clk;
      sys_clk <= src_levels[sys_sel_reg];
    end
  end

  assign lso_rise = low_speed_osc & ~lso_prev_reg;
  assign lso_edge = low_speed_osc ^ lso_prev_reg;
  assign tick_1k = lso_rise && (lso_1k_cnt_reg == 6'(LSO_1K_HALF - 1)) && !slow_tick_clock;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lso_prev_reg <= 1'b0;
      fast_low_power_clock <= 1'b0;
      lso_1k_cnt_reg <= 6'h00;
      slow_tick_clock <= 1'b0;
    end
    else
    begin
      lso_prev_reg <= low_speed_osc;
      fast_low_power_clock <= low_speed_osc;
      if (lso_rise)
      begin
        lso_1k_cnt_reg <= (lso_1k_cnt_reg == 6'(LSO_1K_HALF - 1)) ? 6'h00 : lso_1k_cnt_reg + 6'h01;
        if (lso_1k_cnt_reg == 6'(LSO_1K_HALF - 1))
          slow_tick_clock <= ~slow_tick_clock;
      end
    end
  end

  // divide by three on both edges
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lso_33k_cnt_reg <= 2'h0;
      third_rate_slow_clock <= 1'b0;
    end
    else if (lso_edge)
    begin
      lso_33k_cnt_reg <= (lso_33k_cnt_reg == 2'(LSO_33K_EDGES - 1)) ? 2'h0 : lso_33k_cnt_reg + 2'h1;
      if (lso_33k_cnt_reg == 2'(LSO_33K_EDGES - 1))
        third_rate_slow_clock <= ~third_rate_slow_clock;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || (wr_go && paddr == WAKE_CTRL_OFS && pwdata[31]))
      wake_cnt_reg <= 13'h0000;
    else if (tick_1k && !hibernate && !debug_halt)
      wake_cnt_reg <= wake_cnt_reg + 13'h0001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || (wr_go && paddr == WAKE_CTRL_OFS))
    begin
      wake_phase_reg <= 13'h0000;
      wake_event <= 1'b0;
      wake_irq <= 1'b0;
    end
    else
    begin
      wake_event <= 1'b0;
      wake_irq <= 1'b0;
      if (tick_1k && !hibernate && !debug_halt && wake_period_reg != 13'h0000)
      begin
        if (wake_phase_reg >= wake_period_reg - 13'h0001)
        begin
          wake_phase_reg <= 13'h0000;
          wake_event <= wake_en_reg;
          wake_irq <= wake_en_reg & wake_irq_en_reg;
        end
        else
          wake_phase_reg <= wake_phase_reg + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || !ftw_en_reg)
    begin
      ftw_cnt_reg <= 5'h00;
      ftw_irq <= 1'b0;
    end
    else
    begin
      ftw_irq <= 1'b0;
      if (lso_rise)
      begin
        if (ftw_cnt_reg >= ftw_tc_reg)
        begin
          ftw_cnt_reg <= 5'h00;
          ftw_irq <= ftw_irq_en_reg;
        end
        else
          ftw_cnt_reg <= ftw_cnt_reg + 5'h01;
      end
    end
  end

  // bus divider fed from the system clock path
  assign bus_cfg = '{en: 1'b1, sel: sys_sel_reg, ratio: bus_ratio_reg, skew: 2'h0};

  ccd_clk_divider #(.DIV_W(DIV_W), .HAS_SKEW(1'b0)) u_bus_div (
    .clk_sys(clk_sys),
    .reset(reset),
    .src_levels(src_levels),
    .cfg(bus_cfg),
    .clk_out(bus_div_q)
  );

  assign bus_clk = bus_div_q;
  assign cpu_clk = bus_div_q;

  for (genvar g = 0; g < NUM_DIG_DIV; g++)
  begin : g_dig
    ccd_clk_divider #(.DIV_W(DIV_W), .HAS_SKEW(1'b0)) u_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .src_levels(src_levels),
      .cfg(dig_cfg_reg[g]),
      .clk_out(dig_clk[g])
    );
  end

  for (genvar g = 0; g < NUM_ANA_DIV; g++)
  begin : g_ana
    ccd_clk_divider #(.DIV_W(DIV_W), .HAS_SKEW(1'b1)) u_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .src_levels(src_levels),
      .cfg(ana_cfg_reg[g]),
      .clk_out(ana_clk[g])
    );
  end
endmodule

// [shared/ccd_pkg.sv]
// constants, register map and carrier types for the clock unit
package ccd_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PLL_LOCK_US = 250;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_US * 1000000) / CLK_PERIOD_PS;
  localparam int LSO_1K_HALF = 50;
  localparam int LSO_33K_EDGES = 3;
  localparam int NUM_DIG_DIV = 8;
  localparam int NUM_ANA_DIV = 4;
  localparam int NUM_IMO_RANGES = 6;
  // register byte offsets
  localparam logic [7:0] OSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PLL_DIV_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] WAKE_CTRL_OFS = 8'h0C;
  localparam logic [7:0] FTW_CTRL_OFS = 8'h10;
  localparam logic [7:0] BUS_DIV_OFS = 8'h14;
  localparam logic [7:0] DIG_DIV_OFS = 8'h20;
  localparam logic [7:0] IMO_TRIM_OFS = 8'h40;
  localparam logic [7:0] ANA_DIV_OFS = 8'h60;
  // reset values
  localparam logic [2:0] IMO_FREQ_RST = 3'h0;
  localparam logic [7:0] IMO_TRIM_RST = 8'h80;
  localparam logic [15:0] DIV_RST = 16'h0002;
  localparam logic [5:0] PLL_P_RST = 6'h01;
  localparam logic [5:0] PLL_Q_RST = 6'h08;
  localparam logic [4:0] FTW_TC_RST = 5'h1F;
  localparam logic [12:0] WAKE_PERIOD_RST = 13'h03E8;
  // source indices of the 8-input mux, then the highest IMO frequency code
  localparam logic [2:0] SRC_IMO = 3'h0;
  localparam logic [2:0] SRC_ECO = 3'h1;
  localparam logic [2:0] SRC_FABRIC = 3'h2;
  localparam logic [2:0] SRC_PLL = 3'h3;
  localparam logic [2:0] SRC_DBL = 3'h4;
  localparam logic [2:0] SRC_1K = 3'h5;
  localparam logic [2:0] SRC_100K = 3'h6;
  localparam logic [2:0] SRC_WATCH = 3'h7;
  localparam logic [2:0] IMO_FREQ_MAX = 3'h5;

  typedef enum logic [1:0] {
    CCD_REF_IMO = 2'b00,
    CCD_REF_ECO = 2'b01,
    CCD_REF_FABRIC = 2'b10
  } ccd_ref_e;

  typedef struct packed {
    logic en;
    logic [2:0] sel;
    logic [15:0] ratio;
    logic [1:0] skew;
  } ccd_div_cfg_s;

  localparam ccd_div_cfg_s DIV_CFG_RST = '{en: 1'b0, sel: SRC_IMO, ratio: DIV_RST, skew: 2'h0};
endpackage

// [src/ccd_clk_divider.sv]
// one glitch-free programmable clock divider with optional skew
`timescale 1ns/1ps
module ccd_clk_divider
  import ccd_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter bit HAS_SKEW = 1'b0
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] src_levels,
  input wire ccd_div_cfg_s cfg,
  output logic clk_out
);
  logic [7:0] src_q_reg;
  logic prev_reg;
  logic [2:0] sel_reg;
  logic [DIV_W-1:0] ratio_reg;
  logic [1:0] skew_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic div_reg;
  logic [3:0] dly_reg;
  logic cur;
  logic rise;
  logic wrap;
  logic [DIV_W-1:0] ratio_eff;

  assign cur = src_q_reg[sel_reg];
  assign rise = cur & ~prev_reg;
  assign ratio_eff = (ratio_reg < DIV_W'(2)) ? DIV_W'(2) : ratio_reg;
  assign wrap = rise && (cnt_reg == ratio_eff - DIV_W'(1));

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      src_q_reg <= 8'h00;
      prev_reg <= 1'b0;
    end
    else
    begin
      src_q_reg <= src_levels;
      prev_reg <= cur;
    end
  end

  // config taken at period end, or at any time while the divider is disabled
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sel_reg <= DIV_CFG_RST.sel;
      ratio_reg <= DIV_W'(DIV_CFG_RST.ratio);
      skew_reg <= DIV_CFG_RST.skew;
    end
    else if (!div_reg && (wrap || !cfg.en))
    begin
      sel_reg <= cfg.sel;
      ratio_reg <= DIV_W'(cfg.ratio);
      skew_reg <= cfg.skew;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || !cfg.en)
    begin
      cnt_reg <= '0;
      div_reg <= 1'b0;
    end
    else if (rise)
    begin
      cnt_reg <= wrap ? '0 : cnt_reg + DIV_W'(1);
      div_reg <= wrap ? 1'b1 : ((cnt_reg + DIV_W'(1)) < (ratio_eff >> 1));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dly_reg <= 4'h0;
      clk_out <= 1'b0;
    end
    else
    begin
      dly_reg <= {dly_reg[2:0], div_reg};
      clk_out <= HAS_SKEW ? dly_reg[skew_reg] : dly_reg[0];
    end
  end
endmodule

// [sim/ccd_clock_unit_checker.sv]
// port assertions for the clock unit
`timescale 1ns/1ps
module ccd_clock_unit_checker
  import ccd_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES,
  parameter int DIV_W = 16
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] imo_freq_sel,
  input wire logic pll_enable,
  input wire logic [5:0] pll_in_div,
  input wire logic pll_locked,
  input wire logic bus_clk,
  input wire logic cpu_clk,
  input wire logic wake_event,
  input wire logic ftw_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence apb_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence pll_off;
    !pll_enable [*3];
  endsequence
  ready_timing_a: assert property (apb_setup |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  freq_legal_a: assert property (imo_freq_sel <= IMO_FREQ_MAX) else $error("bad range");
  pll_cfg_hold_a: assert property (!(pready && pwrite) && !$past(pready && pwrite) |=> $stable(pll_in_div))
    else $error("div moved");
  lock_drop_a: assert property (pll_off |-> !pll_locked) else $error("lock while off");
  cpu_bus_same_a: assert property (bus_clk == cpu_clk) else $error("cpu clock differs");
  ftw_pulse_a: assert property (ftw_irq |=> !ftw_irq) else $error("ftw irq held");
  wake_pulse_a: assert property (wake_event |=> !wake_event) else $error("wake held");
endmodule
bind ccd_clock_unit ccd_clock_unit_checker #(.LOCK_CYCLES(LOCK_CYCLES), .DIV_W(DIV_W)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .imo_freq_sel(imo_freq_sel), .pll_enable(pll_enable),
  .pll_in_div(pll_in_div), .pll_locked(pll_locked), .bus_clk(bus_clk), .cpu_clk(cpu_clk),
  .wake_event(wake_event), .ftw_irq(ftw_irq)
);

// [sim/ccd_clock_unit_tb_top.sv]
// self-checking testbench for the clock unit
`timescale 1ns/1ps
module ccd_clock_unit_tb_top;
  import ccd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hibernate = 1'b0;
  logic debug_halt = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, pll_enable, pll_locked, bus_clk, cpu_clk, wake_event, wake_irq, ftw_irq;
  logic dbl_clk, usb_clk, sys_clk, slow_tick_clock, third_rate_slow_clock, fast_low_power_clock;
  logic [2:0] imo_freq_sel;
  logic [7:0] imo_trim, dig_clk;
  logic [5:0] pll_in_div, pll_fb_div;
  logic [3:0] ana_clk;
  wire logic [2:0] ev = {wake_event, wake_irq, ftw_irq};
  wire logic [8:0] dv = {sys_clk, slow_tick_clock, fast_low_power_clock, usb_clk, dbl_clk,
                         third_rate_slow_clock, ana_clk[0], bus_clk, dig_clk[0]};
  int cyc = 0;
  int n_mismatch = 0;
  int n_tests = 0;
  ccd_clock_unit #(.LOCK_CYCLES(20), .DIV_W(16)) dut (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_main_osc(cnt[0]), .fast_crystal_osc(cnt[1]), .fabric_clk(cnt[2]),
    .pll_core_clk(cnt[0]), .low_speed_osc(cnt[1]), .watch_crystal_osc(cnt[3]),
    .hibernate(hibernate), .debug_halt(debug_halt), .imo_freq_sel(imo_freq_sel),
    .imo_trim(imo_trim), .pll_enable(pll_enable), .pll_in_div(pll_in_div),
    .pll_fb_div(pll_fb_div), .pll_locked(pll_locked), .dbl_clk(dbl_clk), .usb_clk(usb_clk), .sys_clk(sys_clk),
    .bus_clk(bus_clk), .cpu_clk(cpu_clk), .dig_clk(dig_clk), .ana_clk(ana_clk),
    .slow_tick_clock(slow_tick_clock), .third_rate_slow_clock(third_rate_slow_clock),
    .fast_low_power_clock(fast_low_power_clock),
    .wake_event(wake_event), .wake_irq(wake_irq), .ftw_irq(ftw_irq)
  );
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  task conclude();
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cnt <= cnt + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task gap(input int i, output int n);
    n = 0;
    do @(posedge clk_sys); while (ev[i] !== 1'b1);
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (ev[i] !== 1'b1);
  endtask
  task divt(input int i, input logic [7:0] a, input logic [31:0] v, input int h, input int p);
    int hi, per;
    apb(1'b1, a, v);
    repeat (2)
    begin
      hi = 0;
      do @(posedge clk_sys); while (dv[i] !== 1'b0);
      do @(posedge clk_sys); while (dv[i] !== 1'b1);
      do
      begin
        @(posedge clk_sys);
        hi++;
      end while (dv[i] === 1'b1 && hi < 200);
      per = hi;
      do
      begin
        @(posedge clk_sys);
        per++;
      end while (dv[i] === 1'b0 && per < 400);
    end
    chk(hi, h);
    chk(per, p);
  endtask
  initial
  begin
    int n;
    logic [31:0] c;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(imo_trim, IMO_TRIM_RST);
    chk(pll_in_div, PLL_P_RST);
    chk(pll_fb_div, PLL_Q_RST);
    chk(pll_locked, 32'h0);
    for (int k = 0; k < 6; k++)
      apb(1'b1, IMO_TRIM_OFS + 8'(4 * k), 32'h10 + k);
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b1, OSC_CTRL_OFS, k);
      chk(imo_freq_sel, k);
      chk(imo_trim, 32'h10 + k);
    end
    apb(1'b1, OSC_CTRL_OFS, 32'h6);
    chk(imo_freq_sel, 32'h5);
    apb(1'b1, PLL_DIV_OFS, 32'h0A03);
    chk(pll_in_div, 32'h3);
    chk(pll_fb_div, 32'hA);
    apb(1'b1, OSC_CTRL_OFS, 32'h100);
    chk(pll_enable, 32'h1);
    chk(pll_locked, 32'h0);
    repeat (30) @(posedge clk_sys);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(q[0], 32'h1);
    chk(pll_locked, 32'h1);
    apb(1'b1, OSC_CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk(pll_locked, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk(e, 32'h1);
    apb(1'b1, 8'h18, 32'hFFFF);
    chk(e, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(e, 32'h0);
    for (int t = 0; t < 32; t += 31)
    begin
      apb(1'b1, FTW_CTRL_OFS, 32'h300 + t);
      gap(0, n);
      gap(0, n);
      chk(n, 4 * (t + 1));
    end
    apb(1'b1, WAKE_CTRL_OFS, 32'h30002);
    gap(1, n);
    gap(1, n);
    chk(n, 800);
    gap(2, n);
    chk(n, 800);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys);
      {debug_halt, hibernate} <= 2'(1 << i);
      apb(1'b0, STATUS_OFS, 32'h0);
      c = q;
      repeat (900) @(posedge clk_sys);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(q[28:16], c[28:16]);
      {debug_halt, hibernate} <= 2'b00;
    end
    apb(1'b0, STATUS_OFS, 32'h0);
    c = q;
    repeat (794) @(posedge clk_sys);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(q[28:16], 13'(c[28:16] + 13'h0002));
    hibernate <= 1'b1;
    apb(1'b1, WAKE_CTRL_OFS, 32'h80030002);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(q[28:16], 32'h0);
    hibernate <= 1'b0;
    divt(0, DIG_DIV_OFS, 32'h01000001, 2, 4);
    divt(0, DIG_DIV_OFS, 32'h01000005, 4, 10);
    divt(0, DIG_DIV_OFS, 32'h01060002, 4, 8);
    divt(1, BUS_DIV_OFS, 32'h3, 2, 6);
    divt(2, ANA_DIV_OFS, 32'h01000004, 4, 8);
    divt(3, STATUS_OFS, 32'h0, 6, 12);
    divt(6, STATUS_OFS, 32'h0, 2, 4);
    divt(7, STATUS_OFS, 32'h0, 200, 400);
    divt(8, STATUS_OFS, 32'h0, 1, 2);
    divt(5, STATUS_OFS, 32'h0, 4, 8);
    divt(4, OSC_CTRL_OFS, 32'h20, 1, 4);
    divt(5, OSC_CTRL_OFS, 32'h1020, 1, 4);
    conclude();
  end
endmodule
